/* File: rtl/pcfg_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef PCFG_REGS_SVH
`define PCFG_REGS_SVH
// ==========================================
// Function configuration space
`define PCFG_OFS_CMDSTAT  8'h04
`define PCFG_OFS_BASE     8'h10
`define PCFG_OFS_RSVD_LO  8'h14
`define PCFG_OFS_RSVD_HI  8'h38
`define PCFG_OFS_INTR     8'h3C
`define PCFG_BIT_MEM_EN   1
`define PCFG_BIT_PERR_EN  6
`define PCFG_BIT_DPD      24
`define PCFG_BIT_DPE      31
`define PCFG_INT_PIN      8'h02
`define PCFG_RST_BASE     12'h000
`define PCFG_RST_LINE     8'h00
// ==========================================
// Host controller registers (APB)
`define PCFG_H_ADDR       8'h00
`define PCFG_H_WDATA      8'h04
`define PCFG_H_CTRL       8'h08
`define PCFG_H_STAT       8'h0C
`define PCFG_H_RDATA      8'h10
`define PCFG_CTL_CMD_LSB  0
`define PCFG_CTL_BE_LSB   4
`define PCFG_CTL_GO       8
`define PCFG_CTL_PERR_EN  9
`define PCFG_CTL_BADPAR   10
`define PCFG_CTL_IDSEL    11
`define PCFG_ST_BUSY      0
`define PCFG_ST_DONE      1
`define PCFG_ST_MABORT    2
`define PCFG_ST_PERR      3
// ==========================================
// Timing
`define PCFG_DEVSEL_TMO   3'h4
`endif

/* File: rtl/pcfg_pkg.sv */
// Types and parity helper shared by both ends
package pcfg_pkg;
  // Bus commands as carried on the byte-enable lines
  typedef enum logic [3:0] {
    PCFG_CMD_MRD = 4'h6,
    PCFG_CMD_MWR = 4'h7,
    PCFG_CMD_CRD = 4'hA,
    PCFG_CMD_CWR = 4'hB
  } pcfg_cmd_t;
  // Device end states
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_EXP  = 3'b010,
    D_RESP = 3'b011,
    D_PAR  = 3'b100,
    D_PERR = 3'b101
  } pcfg_dst_t;
  // Host end states
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_ADR  = 3'b001,
    H_DAT  = 3'b010,
    H_PAR  = 3'b011,
    H_PERR = 3'b100
  } pcfg_hst_t;
  // Even parity across address/data and byte-enable lines
  function automatic logic pcfg_even_par(input logic [31:0] ad, input logic [3:0] cbe_n);
    return ^{ad, cbe_n};
  endfunction
endpackage

/* File: rtl/pcfg_bus_if.sv */
// Shared bus between host end and device end
`timescale 1ns/1ps
interface pcfg_bus_if;
  logic [31:0] h_ad, d_ad, ad;
  logic        h_ad_oe, d_ad_oe;
  logic [3:0]  cbe_n;
  logic        frame_n, irdy_n, idsel;
  logic        d_devsel_n, d_trdy_n, d_tgt_oe, devsel_n, trdy_n;
  logic        h_par, h_par_oe, d_par, d_par_oe, par;
  logic        h_perr_n, h_perr_oe, d_perr_n, d_perr_oe, perr_n;
  // Wire resolution; undriven lines settle low or pulled high
  assign ad       = h_ad_oe ? h_ad : (d_ad_oe ? d_ad : 32'h0);
  assign devsel_n = d_tgt_oe ? d_devsel_n : 1'b1;
  assign trdy_n   = d_tgt_oe ? d_trdy_n : 1'b1;
  assign par      = h_par_oe ? h_par : (d_par_oe ? d_par : 1'b0);
  assign perr_n   = (h_perr_oe & ~h_perr_n) | (d_perr_oe & ~d_perr_n) ? 1'b0 : 1'b1;
  modport dev (
    input  ad, cbe_n, frame_n, irdy_n, idsel, par, perr_n,
    output d_ad, d_ad_oe, d_devsel_n, d_trdy_n, d_tgt_oe,
    output d_par, d_par_oe, d_perr_n, d_perr_oe
  );
  modport host (
    input  ad, devsel_n, trdy_n, par, perr_n,
    output h_ad, h_ad_oe, cbe_n, frame_n, irdy_n, idsel,
    output h_par, h_par_oe, h_perr_n, h_perr_oe
  );
endinterface

/* File: rtl/pcfg_dev.sv */
// Device end: config space, window decode, expansion forwarding, parity
//
// Implementation choice: the expansion request/acknowledge port.
`timescale 1ns/1ps
`include "pcfg_regs.svh"
module pcfg_dev #(
  parameter logic [31:0] EXP_SIZE = 32'h0010_0000 // Implemented bytes in window
) (
  input  wire logic        clk_sys_i,     // System clock
  input  wire logic        srst_i,        // Sync reset, active high
  pcfg_bus_if.dev          bus,           // Bus to host
  input  wire logic        mst_busy_i,    // Own master data phase active
  input  wire logic        mst_par_err_i, // Own master saw bad read parity
  output logic             desc_req_o,    // Pulse: write error descriptor
  output logic             exp_oe_o,      // Expansion outputs enabled
  output logic             exp_req_o,     // Expansion cycle request
  output logic             exp_we_o,      // Expansion write
  output logic [19:0]      exp_addr_o,    // Expansion byte address
  output logic [31:0]      exp_wdata_o,   // Expansion write data
  output logic [3:0]       exp_be_o,      // Expansion byte enables
  input  wire logic        exp_ack_i,     // Expansion cycle done
  input  wire logic [31:0] exp_rdata_i    // Expansion read data
);
  import pcfg_pkg::*;

  // ==========================================
  // State
  pcfg_dst_t   st_ff, nxt_st;
  logic [31:0] addr_ff, wdata_ff, rdata_ff;
  logic [3:0]  cmd_ff, be_n_ff;
  logic        idsel_ff;
  logic [11:0] base_ff;
  logic        mem_en_ff, perr_en_ff;
  logic [7:0]  line_ff;
  logic        dpe_ff, dpd_ff, desc_ff;
  logic        par_ff, par_oe_ff;
  logic        exp_req_ff, exp_we_ff;
  logic [19:0] exp_addr_ff;
  logic [31:0] exp_wdata_ff;
  logic [3:0]  exp_be_ff;

  // ==========================================
  // Decode
  wire logic        is_wr, is_cfg, is_mem, hit, in_rng;
  wire logic        adr_bad, dat_bad, cfg_wr, ofs_cs, ofs_base, ofs_intr;
  wire logic [7:0]  cfg_ofs;
  wire logic [3:0]  be;
  wire logic [31:0] cmdstat_rd, cfg_rdata;
  wire logic        set_dpe, clr_dpe, set_dpd, clr_dpd;

  // Command and window decode
  assign is_wr   = cmd_ff[0];
  assign is_cfg  = idsel_ff & (cmd_ff == PCFG_CMD_CRD || cmd_ff == PCFG_CMD_CWR);
  assign is_mem  = mem_en_ff & (cmd_ff == PCFG_CMD_MRD || cmd_ff == PCFG_CMD_MWR)
                   & (addr_ff[31:20] == base_ff);
  assign adr_bad = bus.par != pcfg_even_par(addr_ff, cmd_ff);
  assign hit     = (is_cfg | is_mem) & ~adr_bad;
  assign in_rng  = {12'h000, addr_ff[19:0]} < EXP_SIZE;
  assign dat_bad = bus.par != pcfg_even_par(wdata_ff, be_n_ff);

  // Configuration register selection
  assign cfg_ofs  = {addr_ff[7:2], 2'b00};
  assign be       = ~be_n_ff;
  assign ofs_cs   = cfg_ofs == `PCFG_OFS_CMDSTAT;
  assign ofs_base = cfg_ofs == `PCFG_OFS_BASE;
  assign ofs_intr = cfg_ofs == `PCFG_OFS_INTR;
  assign cfg_wr   = (st_ff == D_RESP) & is_cfg & is_wr;

  // Read views; everything not listed, 14h-38h included, reads zero
  assign cmdstat_rd = {dpe_ff, 6'h00, dpd_ff, 17'h00000, perr_en_ff, 4'h0, mem_en_ff, 1'b0};
  assign cfg_rdata  = ofs_cs   ? cmdstat_rd :
                      ofs_base ? {base_ff, 20'h00000} :
                      ofs_intr ? {16'h0000, `PCFG_INT_PIN, line_ff} :
                      32'h0000_0000;

  // Parity status: set wins over a write-one clear
  assign set_dpe = ((st_ff == D_ADDR) & adr_bad)
                 | ((st_ff == D_PAR) & is_wr & dat_bad)
                 | (mst_busy_i & mst_par_err_i);
  assign clr_dpe = cfg_wr & ofs_cs & be[3] & wdata_ff[`PCFG_BIT_DPE];
  assign set_dpd = perr_en_ff & mst_busy_i & (~bus.perr_n | mst_par_err_i);
  assign clr_dpd = cfg_wr & ofs_cs & be[3] & wdata_ff[`PCFG_BIT_DPD];

  // ==========================================
  // Target sequencer
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      D_IDLE: begin
        if (!bus.frame_n) begin
          nxt_st = D_ADDR;
        end
      end
      D_ADDR: begin
        if (!hit) begin
          nxt_st = D_IDLE;
        end else if (is_mem) begin
          nxt_st = D_EXP;
        end else begin
          nxt_st = D_RESP;
        end
      end
      D_EXP: begin
        if (!exp_req_ff || exp_ack_i) begin
          nxt_st = D_RESP;
        end
      end
      D_RESP: nxt_st = D_PAR;
      D_PAR: begin
        if (is_wr && dat_bad && perr_en_ff) begin
          nxt_st = D_PERR;
        end else begin
          nxt_st = D_IDLE;
        end
      end
      D_PERR: nxt_st = D_IDLE;
      default: nxt_st = D_IDLE;
    endcase
  end

  // State register; reset drops any cycle at once
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_ff <= D_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Address, data and command capture
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      addr_ff  <= 32'h0000_0000;
      cmd_ff   <= 4'h0;
      idsel_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      be_n_ff  <= 4'hF;
    end else if (st_ff == D_IDLE && !bus.frame_n) begin
      addr_ff  <= bus.ad;
      cmd_ff   <= bus.cbe_n;
      idsel_ff <= bus.idsel;
    end else if (st_ff == D_ADDR) begin
      wdata_ff <= bus.ad;
      be_n_ff  <= bus.cbe_n;
    end
  end

  // Expansion port request; out-of-range locations never reach it
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      exp_req_ff   <= 1'b0;
      exp_we_ff    <= 1'b0;
      exp_addr_ff  <= 20'h00000;
      exp_wdata_ff <= 32'h0000_0000;
      exp_be_ff    <= 4'h0;
    end else if (st_ff == D_ADDR && hit && is_mem && in_rng) begin
      exp_req_ff   <= 1'b1;
      exp_we_ff    <= is_wr;
      exp_addr_ff  <= addr_ff[19:0];
      exp_wdata_ff <= bus.ad;
      exp_be_ff    <= ~bus.cbe_n;
    end else if (exp_ack_i) begin
      exp_req_ff   <= 1'b0;
    end
  end

  // Read data: config view, expansion data, or zero
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (st_ff == D_ADDR) begin
      rdata_ff <= is_cfg ? cfg_rdata : 32'h0000_0000;
    end else if (st_ff == D_EXP && exp_req_ff && exp_ack_i && !exp_we_ff) begin
      rdata_ff <= exp_rdata_i;
    end
  end

  // ==========================================
  // Writable configuration bits; unlisted words drop writes
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mem_en_ff  <= 1'b0;
      perr_en_ff <= 1'b0;
      base_ff    <= `PCFG_RST_BASE;
      line_ff    <= `PCFG_RST_LINE;
    end else if (cfg_wr) begin
      if (ofs_cs && be[0]) begin
        mem_en_ff  <= wdata_ff[`PCFG_BIT_MEM_EN];
        perr_en_ff <= wdata_ff[`PCFG_BIT_PERR_EN];
      end
      if (ofs_base && be[3]) begin
        base_ff[11:4] <= wdata_ff[31:24];
      end
      if (ofs_base && be[2]) begin
        base_ff[3:0] <= wdata_ff[23:20];
      end
      if (ofs_intr && be[0]) begin
        line_ff <= wdata_ff[7:0];
      end
    end
  end

  // Parity status and descriptor request
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      dpe_ff  <= 1'b0;
      dpd_ff  <= 1'b0;
      desc_ff <= 1'b0;
    end else begin
      dpe_ff  <= set_dpe | (dpe_ff & ~clr_dpe);
      dpd_ff  <= set_dpd | (dpd_ff & ~clr_dpd);
      desc_ff <= set_dpd;
    end
  end

  // Parity follows the cycle in which read data was driven
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      par_ff    <= 1'b0;
      par_oe_ff <= 1'b0;
    end else begin
      par_ff    <= pcfg_even_par(rdata_ff, bus.cbe_n);
      par_oe_ff <= (st_ff == D_RESP) & ~is_wr;
    end
  end

  // ==========================================
  // Bus drivers; enables drop combinationally under reset
  assign bus.d_ad       = rdata_ff;
  assign bus.d_ad_oe    = (st_ff == D_RESP) & ~is_wr & ~srst_i;
  assign bus.d_par      = par_ff;
  assign bus.d_par_oe   = par_oe_ff & ~srst_i;
  assign bus.d_tgt_oe   = (st_ff != D_IDLE) & ~srst_i;
  assign bus.d_devsel_n = ~(((st_ff == D_ADDR) & hit) | (st_ff == D_EXP) | (st_ff == D_RESP));
  assign bus.d_trdy_n   = ~(st_ff == D_RESP);
  assign bus.d_perr_n   = 1'b0;
  assign bus.d_perr_oe  = (st_ff == D_PERR) & ~srst_i;

  // Expansion port outputs
  assign exp_oe_o    = ~srst_i;
  assign exp_req_o   = exp_req_ff;
  assign exp_we_o    = exp_we_ff;
  assign exp_addr_o  = exp_addr_ff;
  assign exp_wdata_o = exp_wdata_ff;
  assign exp_be_o    = exp_be_ff;
  assign desc_req_o  = desc_ff;
endmodule

/* File: rtl/pcfg_host.sv */
// Host end: APB-programmed bus master for config and memory cycles
`timescale 1ns/1ps
`include "pcfg_regs.svh"
module pcfg_host (
  input  wire logic        clk_sys_i, // System clock
  input  wire logic        srst_i,    // Sync reset, active high
  input  wire logic [7:0]  paddr_i,   // APB address
  input  wire logic        psel_i,    // APB select
  input  wire logic        penable_i, // APB enable
  input  wire logic        pwrite_i,  // APB write
  input  wire logic [31:0] pwdata_i,  // APB write data
  output logic [31:0]      prdata_o,  // APB read data
  output logic             pready_o,  // APB ready
  output logic             pslverr_o, // APB error, unmapped
  pcfg_bus_if.host         bus        // Bus to device
);
  import pcfg_pkg::*;

  // ==========================================
  // State
  pcfg_hst_t   st_ff, nxt_st;
  logic [31:0] addr_ff, wdata_ff, rdata_ff, prdata_ff;
  logic [3:0]  cmd_ff, be_n_ff;
  logic        perr_en_ff, badpar_ff, idsel_ff;
  logic        done_ff, mabort_ff, perr_ff, seen_ff;
  logic [2:0]  cnt_ff;
  logic        par_ff, par_oe_ff;

  // ==========================================
  // APB decode
  wire logic        mapped, acc, wr, go, is_wr, ad_oe, rd_bad, abort, ended;
  wire logic [31:0] rd_mux, ctrl_rd, stat_rd;
  wire logic [31:0] ad_drv;
  wire logic [3:0]  cbe_drv;
  assign mapped  = paddr_i == `PCFG_H_ADDR || paddr_i == `PCFG_H_WDATA
                || paddr_i == `PCFG_H_CTRL || paddr_i == `PCFG_H_STAT
                || paddr_i == `PCFG_H_RDATA;
  assign acc     = psel_i & penable_i;
  assign wr      = acc & pwrite_i & mapped;
  assign go      = wr & (paddr_i == `PCFG_H_CTRL) & pwdata_i[`PCFG_CTL_GO] & (st_ff == H_IDLE);
  assign ctrl_rd = {20'h00000, idsel_ff, badpar_ff, perr_en_ff, 1'b0, be_n_ff, cmd_ff};
  assign stat_rd = {28'h0000000, perr_ff, mabort_ff, done_ff, st_ff != H_IDLE};
  assign rd_mux  = paddr_i == `PCFG_H_ADDR  ? addr_ff  :
                   paddr_i == `PCFG_H_WDATA ? wdata_ff :
                   paddr_i == `PCFG_H_CTRL  ? ctrl_rd  :
                   paddr_i == `PCFG_H_STAT  ? stat_rd  :
                   paddr_i == `PCFG_H_RDATA ? rdata_ff : 32'h0000_0000;
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~mapped;
  assign prdata_o  = prdata_ff;

  // Master cycle decode
  assign is_wr   = cmd_ff[0];
  assign ad_oe   = (st_ff == H_ADR) | ((st_ff == H_DAT) & is_wr);
  assign ad_drv  = (st_ff == H_ADR) ? addr_ff : wdata_ff;
  assign cbe_drv = (st_ff == H_ADR) ? cmd_ff : be_n_ff;
  assign rd_bad  = ~is_wr & (bus.par != pcfg_even_par(rdata_ff, be_n_ff));
  assign abort   = (st_ff == H_DAT) & ~seen_ff & bus.devsel_n & (cnt_ff == `PCFG_DEVSEL_TMO);
  assign ended   = (nxt_st == H_IDLE) & (st_ff != H_IDLE);

  // ==========================================
  // Master sequencer
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      H_IDLE: begin
        if (go) begin
          nxt_st = H_ADR;
        end
      end
      H_ADR: nxt_st = H_DAT;
      H_DAT: begin
        if (!bus.trdy_n) begin
          nxt_st = H_PAR;
        end else if (abort) begin
          nxt_st = H_IDLE;
        end
      end
      H_PAR: nxt_st = (rd_bad && perr_en_ff) ? H_PERR : H_IDLE;
      H_PERR: nxt_st = H_IDLE;
      default: nxt_st = H_IDLE;
    endcase
  end

  // APB-written registers and read capture in setup phase
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      addr_ff    <= 32'h0000_0000;
      wdata_ff   <= 32'h0000_0000;
      cmd_ff     <= 4'h0;
      be_n_ff    <= 4'hF;
      perr_en_ff <= 1'b0;
      badpar_ff  <= 1'b0;
      idsel_ff   <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      if (psel_i && !penable_i) begin
        prdata_ff <= rd_mux;
      end
      if (wr && st_ff == H_IDLE && paddr_i == `PCFG_H_ADDR) begin
        addr_ff <= pwdata_i;
      end
      if (wr && st_ff == H_IDLE && paddr_i == `PCFG_H_WDATA) begin
        wdata_ff <= pwdata_i;
      end
      if (wr && st_ff == H_IDLE && paddr_i == `PCFG_H_CTRL) begin
        cmd_ff     <= pwdata_i[`PCFG_CTL_CMD_LSB +: 4];
        be_n_ff    <= pwdata_i[`PCFG_CTL_BE_LSB +: 4];
        perr_en_ff <= pwdata_i[`PCFG_CTL_PERR_EN];
        badpar_ff  <= pwdata_i[`PCFG_CTL_BADPAR];
        idsel_ff   <= pwdata_i[`PCFG_CTL_IDSEL];
      end
    end
  end

  // Sequencer state, devsel timeout and outcome flags
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_ff     <= H_IDLE;
      cnt_ff    <= 3'h0;
      seen_ff   <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      done_ff   <= 1'b0;
      mabort_ff <= 1'b0;
      perr_ff   <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      cnt_ff  <= (st_ff == H_DAT) ? cnt_ff + 3'h1 : 3'h0;
      seen_ff <= (st_ff == H_DAT) & (seen_ff | ~bus.devsel_n);
      if (st_ff == H_DAT && !bus.trdy_n && !is_wr) begin
        rdata_ff <= bus.ad;
      end
      // GO clears the outcome flags; an event in the same cycle still sets them
      done_ff   <= (done_ff & ~go) | ended;
      mabort_ff <= (mabort_ff & ~go) | abort;
      perr_ff   <= (perr_ff & ~go) | ((st_ff == H_PAR) & rd_bad) | (~bus.perr_n & ~bus.h_perr_oe);
    end
  end

  // Parity one clock after each driven address or write data
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      par_ff    <= 1'b0;
      par_oe_ff <= 1'b0;
    end else begin
      // Injected fault hits address parity on reads, data parity on writes
      par_ff    <= pcfg_even_par(ad_drv, cbe_drv) ^ (badpar_ff & (~is_wr | (st_ff == H_DAT)));
      par_oe_ff <= ad_oe;
    end
  end

  // ==========================================
  // Bus drivers
  assign bus.h_ad      = ad_drv;
  assign bus.h_ad_oe   = ad_oe;
  assign bus.cbe_n     = (st_ff == H_IDLE) ? 4'hF : cbe_drv;
  assign bus.frame_n   = ~(st_ff == H_ADR);
  assign bus.irdy_n    = ~(st_ff == H_DAT);
  assign bus.idsel     = (st_ff == H_ADR) & idsel_ff;
  assign bus.h_par     = par_ff;
  assign bus.h_par_oe  = par_oe_ff;
  assign bus.h_perr_n  = 1'b0;
  assign bus.h_perr_oe = st_ff == H_PERR;
endmodule

/* File: bench/pcfg_bus_properties.sv */
// Assertions on the shared bus between host end and device end
`timescale 1ns/1ps
module pcfg_bus_properties (
  input wire logic        clk_sys_i, // Clock
  input wire logic        srst_i,    // Sync reset
  input wire logic [31:0] ad,        // Resolved data lines
  input wire logic [31:0] d_ad,      // Device data
  input wire logic        d_ad_oe,   // Device data enable
  input wire logic [3:0]  cbe_n,     // Command or byte enables
  input wire logic        frame_n,   // Frame
  input wire logic        idsel,     // Config select
  input wire logic        devsel_n,  // Claim
  input wire logic        trdy_n,    // Target ready
  input wire logic        d_tgt_oe,  // Device target enable
  input wire logic        h_ad_oe,   // Host data enable
  input wire logic        h_par_oe,  // Host parity enable
  input wire logic        d_par,     // Device parity
  input wire logic        d_par_oe,  // Device parity enable
  input wire logic        d_perr_oe, // Device error enable
  input wire logic        par,       // Resolved parity
  input wire logic        perr_n     // Resolved error line
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // ==========================================
  // Bus properties
  reset_float_a: assert property (disable iff (1'b0)
    srst_i |-> !(d_ad_oe | d_tgt_oe | d_par_oe | d_perr_oe)) else $error("device drives in reset");
  claim_after_addr_a: assert property ($fell(devsel_n) |-> $past(!frame_n))
    else $error("claim without address phase");
  cfg_idsel_a: assert property ($fell(frame_n) && cbe_n[3:1] == 3'b101 && !idsel |=> devsel_n)
    else $error("config cycle claimed without select");
  bad_cmd_a: assert property
    ($fell(frame_n) && !(cbe_n inside {4'h6, 4'h7, 4'hA, 4'hB}) |=> devsel_n)
    else $error("unknown command claimed");
  trdy_bound_a: assert property ($fell(devsel_n) |-> ##[1:40] !trdy_n)
    else $error("claimed cycle never completes");
  trdy_pulse_a: assert property ($fell(trdy_n) |=> trdy_n)
    else $error("target ready longer than one cycle");
  rd_data_trdy_a: assert property (d_ad_oe |-> !trdy_n)
    else $error("device data outside ready cycle");
  dev_par_a: assert property
    ($past(d_ad_oe) |-> d_par_oe && d_par == ^{$past(d_ad), $past(cbe_n)})
    else $error("device parity wrong or late");
  host_par_a: assert property ($past(h_ad_oe) |-> h_par_oe)
    else $error("host parity not driven");
  perr_cause_a: assert property
    (!perr_n |-> $past(par) != ^{$past(ad, 2), $past(cbe_n, 2)})
    else $error("error flagged on good parity");
endmodule

/* File: bench/tb.sv */
// Self-checking bench: host end and device end joined by the shared bus
`timescale 1ns/1ps
`include "pcfg_regs.svh"
module tb;
  localparam logic [31:0] BASE = 32'h1230_0000; // Window base used
  logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, exp_rdata, exp_wdata, l_wd;
  logic        pready, pslverr, err, desc, exp_oe, exp_req, exp_we, l_we;
  logic        mst_busy = 1'b0, mst_err = 1'b0, exp_ack = 1'b0, bad_par = 1'b0, no_sel = 1'b0;
  logic [19:0] exp_addr, l_addr;
  logic [3:0]  exp_be, l_be;
  logic [1:0]  dly = 2'h0;
  int          n_mismatch = 0, total_checks = 0, n_exp = 0, n_desc = 0, cyc = 0;

  pcfg_bus_if pcfg_bus_if_i ();
  pcfg_host pcfg_host_i (.clk_sys_i(clk), .srst_i(srst), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .bus(pcfg_bus_if_i.host));
  pcfg_dev #(.EXP_SIZE(32'h0000_1000)) pcfg_dev_i (.clk_sys_i(clk), .srst_i(srst),
    .bus(pcfg_bus_if_i.dev), .mst_busy_i(mst_busy), .mst_par_err_i(mst_err),
    .desc_req_o(desc), .exp_oe_o(exp_oe), .exp_req_o(exp_req), .exp_we_o(exp_we),
    .exp_addr_o(exp_addr), .exp_wdata_o(exp_wdata), .exp_be_o(exp_be), .exp_ack_i(exp_ack),
    .exp_rdata_i(exp_rdata));
  pcfg_bus_properties pcfg_bus_properties_i (.clk_sys_i(clk), .srst_i(srst),
    .ad(pcfg_bus_if_i.ad), .d_ad(pcfg_bus_if_i.d_ad), .d_ad_oe(pcfg_bus_if_i.d_ad_oe),
    .cbe_n(pcfg_bus_if_i.cbe_n), .frame_n(pcfg_bus_if_i.frame_n), .idsel(pcfg_bus_if_i.idsel),
    .devsel_n(pcfg_bus_if_i.devsel_n), .trdy_n(pcfg_bus_if_i.trdy_n),
    .d_tgt_oe(pcfg_bus_if_i.d_tgt_oe), .h_ad_oe(pcfg_bus_if_i.h_ad_oe),
    .h_par_oe(pcfg_bus_if_i.h_par_oe), .d_par(pcfg_bus_if_i.d_par),
    .d_par_oe(pcfg_bus_if_i.d_par_oe), .d_perr_oe(pcfg_bus_if_i.d_perr_oe),
    .par(pcfg_bus_if_i.par), .perr_n(pcfg_bus_if_i.perr_n));

  // Clock
  always #2 clk = ~clk;
  // Read data only valid in the ack cycle; otherwise a changed pattern
  assign exp_rdata = exp_ack ? 32'hA5A5_5A5A : 32'h5A5A_A5A5;
  // Slow expansion responder, event counters and run limit
  always @(posedge clk) begin
    exp_ack <= exp_req && !exp_ack && dly == 2'h2;
    dly <= (exp_req && !exp_ack) ? dly + 2'h1 : 2'h0;
    if (exp_ack) begin
      n_exp <= n_exp + 1;
      l_we <= exp_we;
      l_addr <= exp_addr;
      l_wd <= exp_wdata;
      l_be <= exp_be;
    end
    if (desc === 1'b1) n_desc <= n_desc + 1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      test_done;
    end
  end

  // ==========================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // One APB transfer, held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One bus cycle through the host end; returns status and read data
  task automatic op(input logic [3:0] cmd, input logic [31:0] a, input logic [31:0] d,
                    output logic [31:0] st, output logic [31:0] q);
    int n;
    apb(1'b1, `PCFG_H_ADDR, a, q);
    apb(1'b1, `PCFG_H_WDATA, d, q);
    apb(1'b1, `PCFG_H_CTRL, {20'h0, cmd[3] & ~no_sel, bad_par, 2'b11, 4'h0, cmd}, q);
    n = 0;
    do begin
      apb(1'b0, `PCFG_H_STAT, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 60);
    apb(1'b0, `PCFG_H_RDATA, 32'h0, q);
  endtask
  // Parity error seen during an own master data phase
  task automatic mst_fault;
    @(posedge clk);
    mst_busy <= 1'b1;
    mst_err <= 1'b1;
    @(posedge clk);
    mst_busy <= 1'b0;
    mst_err <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] st, q;
    int          k;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    op(4'hA, 32'h10, 32'h0, st, q);
    check(q, 32'h0, "base after reset");
    op(4'hA, 32'h3C, 32'h0, st, q);
    check(q, 32'h0000_0200, "pin and line after reset");
    op(4'hB, 32'h10, 32'hFFFF_FFFF, st, q);
    op(4'hA, 32'h10, 32'h0, st, q);
    check(q, 32'hFFF0_0000, "base size bits");
    check(q & 32'hF, 32'h0, "base type bits");
    for (k = 32'h14; k <= 32'h38; k += 4) begin
      op(4'hB, k, 32'hFFFF_FFFF, st, q);
      op(4'hA, k, 32'h0, st, q);
      check(q, 32'h0, "reserved word");
    end
    op(4'hB, 32'h3C, 32'hFFFF_FFFF, st, q);
    op(4'hA, 32'h3C, 32'h0, st, q);
    check(q, 32'h0000_02FF, "line byte writable");
    op(4'hB, 32'h10, BASE, st, q);
    op(4'h6, BASE + 32'h40, 32'h0, st, q);
    check(st & 32'h6, 32'h6, "claim while disabled");
    op(4'hB, 32'h04, 32'h0000_0042, st, q);
    op(4'h7, BASE + 32'h40, 32'h1357_9BDF, st, q);
    check(st & 32'h6, 32'h2, "write claimed");
    check({11'h0, l_we, l_addr}, {11'h0, 1'b1, 20'h00040}, "forwarded write");
    check(l_wd, 32'h1357_9BDF, "forwarded data");
    check({28'h0, l_be}, 32'hF, "forwarded byte enables");
    op(4'h6, BASE + 32'h44, 32'h0, st, q);
    check(q, 32'hA5A5_5A5A, "forwarded read");
    k = n_exp;
    op(4'h6, BASE + 32'h2000, 32'h0, st, q);
    check(q, 32'h0, "unimplemented read");
    op(4'h7, BASE + 32'h2000, 32'hFFFF_FFFF, st, q);
    check(n_exp - k, 32'h0, "unimplemented not forwarded");
    op(4'h6, 32'h1240_0040, 32'h0, st, q);
    check(st & 32'h6, 32'h6, "miss not claimed");
    op(4'h2, BASE + 32'h40, 32'h0, st, q);
    check(st & 32'h6, 32'h6, "other command not claimed");
    mst_fault;
    check(n_desc, 32'h1, "descriptor request");
    op(4'hA, 32'h04, 32'h0, st, q);
    check(q, 32'h8100_0042, "parity status bits");
    op(4'hB, 32'h04, 32'hFF00_0002, st, q);
    mst_fault;
    op(4'hA, 32'h04, 32'h0, st, q);
    check(q, 32'h8000_0002, "status with response off");
    check(n_desc, 32'h1, "no descriptor with response off");
    op(4'hB, 32'h04, 32'hFF00_0042, st, q);
    bad_par = 1'b1;
    op(4'h7, BASE + 32'h48, 32'h0000_0001, st, q);
    apb(1'b0, `PCFG_H_STAT, 32'h0, st);
    check(st & 32'hE, 32'hA, "data parity flagged");
    op(4'h6, BASE + 32'h40, 32'h0, st, q);
    check(st & 32'h6, 32'h6, "address parity not claimed");
    check(n_desc, 32'h1, "no descriptor on bus parity");
    bad_par = 1'b0;
    op(4'hA, 32'h04, 32'h0, st, q);
    check(q, 32'h8000_0042, "detected parity status");
    no_sel = 1'b1;
    op(4'hA, 32'h10, 32'h0, st, q);
    check(st & 32'h6, 32'h6, "config without select");
    no_sel = 1'b0;
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    #1 check({31'h0, exp_oe}, 32'h0, "expansion outputs in reset");
    @(posedge clk);
    srst <= 1'b0;
    op(4'hA, 32'h04, 32'h0, st, q);
    check(q, 32'h0, "command after reset");
    op(4'hA, 32'h10, 32'h0, st, q);
    check(q, 32'h0, "base after second reset");
    apb(1'b0, 8'h20, 32'h0, q);
    check({31'h0, err}, 32'h1, "unmapped host register");
    test_done;
  end
endmodule
